// >>> hw/alert_cfg_pkg.sv
// Purpose: constants for the event-threshold and measurement-offset configuration block
// Assumes: 16-bit threshold, offset and measurement words
// Notes:   threshold words pack humidity in the upper field and temperature in the lower field
package alert_cfg_pkg;
	localparam int          WORD_W          = 16;
	localparam int          HUM_FIELD_W     = 7;
	localparam int          TMP_FIELD_W     = 9;
	localparam int          HUM_FIELD_LSB   = 9;
	localparam int          OFS_MAG_W       = 7;
	localparam int          HUM_SIGN_BIT    = 15;
	localparam int          HUM_MAG_LSB     = 8;
	localparam int          TMP_SIGN_BIT    = 7;
	localparam int          TMP_MAG_LSB     = 0;
	localparam int          HUM_OFS_ALIGN   = 7;
	localparam int          TMP_OFS_ALIGN   = 6;
	localparam logic [15:0] SET_HIGH_RST    = 16'hCD33;
	localparam logic [15:0] CLEAR_HIGH_RST  = 16'hCB2D;
	localparam logic [15:0] SET_LOW_RST     = 16'h3266;
	localparam logic [15:0] CLEAR_LOW_RST   = 16'h3869;
	localparam logic [15:0] OFFSET_RST      = 16'h0000;
	localparam logic [7:0]  CRC_INIT        = 8'hFF;
	localparam logic [7:0]  CRC_POLY        = 8'h31;
	localparam logic [1:0]  SEL_SET_HIGH    = 2'h0;
	localparam logic [1:0]  SEL_CLEAR_HIGH  = 2'h1;
	localparam logic [1:0]  SEL_SET_LOW     = 2'h2;
	localparam logic [1:0]  SEL_CLEAR_LOW   = 2'h3;
	localparam int          NVM_WORDS       = 5;
	localparam logic [2:0]  NVM_OFFSET_ADDR = 3'h4;
	localparam int          PROG_TIME_US    = 50000;
	localparam int          CLK_MHZ         = 10;
	localparam int          PROG_CYCLES     = PROG_TIME_US * CLK_MHZ;
endpackage : alert_cfg_pkg

// >>> hw/threshold_crc8.sv
// Purpose: CRC-8 over one 16-bit word, polynomial 0x31, initial 0xFF
// Assumes: purely combinational use
// Notes:   data enters msb first
`timescale 1ns/10ps
module threshold_crc8 (
	input  wire logic [15:0] data_i, // word to protect
	output logic      [7:0]  crc_o   // computed check byte
);
	always_comb begin
		logic [7:0] c;
		c = alert_cfg_pkg::CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			if (c[7] ^ data_i[i]) begin
				c = {c[6:0], 1'b0} ^ alert_cfg_pkg::CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		crc_o = c;
	end
endmodule : threshold_crc8

// >>> hw/nvm_store.sv
// Purpose: small non-volatile word store with registered read data
// Assumes: contents persist across rst_i; only a fresh power-up loses them
// Notes:   valid bit per word tells whether a factory default is overridden
`timescale 1ns/10ps
module nvm_store #(
	parameter int DEPTH = 5,
	parameter int AW    = 3
) (
	input  wire logic          core_clk_i, // clock
	input  wire logic          wr_i,       // write strobe
	input  wire logic [AW-1:0] waddr_i,    // write address
	input  wire logic [15:0]   wdata_i,    // write data
	input  wire logic [AW-1:0] raddr_i,    // read address
	output logic      [15:0]   rdata_o,    // registered read data
	output logic               rvalid_o    // word at raddr has been programmed
);
	initial begin
		if (DEPTH > (1 << AW)) $error("nvm_store depth exceeds address range");
	end

	logic [15:0]      mem [DEPTH];
	logic [DEPTH-1:0] programmed = '0;

	always_ff @(posedge core_clk_i) begin
		if (wr_i) begin
			mem[waddr_i]        <= wdata_i;
			programmed[waddr_i] <= 1'b1;
		end
		rdata_o  <= mem[raddr_i];
		rvalid_o <= programmed[raddr_i];
	end
endmodule : nvm_store

// >>> hw/alert_threshold_offset_config.sv
// Purpose: event thresholds, event output, measurement offset and non-volatile storage of both
// Assumes: command decode supplies one-cycle strobes with data and check byte
// Notes:   busy_o high means the bus must answer with NACK to any traffic
//
// Summary of operation
// - each threshold is 16 bits: humidity top 7 bits over temperature top 9 bits.
// - full results kept; only truncated upper bits are compared with thresholds.
// - after reset set-high, clear-high, set-low load defaults unless stored words exist.
// - after reset clear-low loads its default unless a stored word exists.
// - threshold write with wrong CRC is answered with a NACK.
// - temperature tracking stops when set-low temperature exceeds set-high temperature.
// - humidity tracking stops when set-low humidity exceeds set-high humidity.
// - transfer command stores thresholds; stored words replace defaults after reset.
// - offset bit 15 signs humidity, bit 7 signs temperature; set means add.
// - humidity correction uses raw humidity and its offset only, never a temperature result.
// - each offset write programs storage; bus is refused until done.
// - offset word packs two 7-bit magnitudes and two sign bits.
// - humidity magnitude aligns with result bits 13 down to 7.
// - temperature magnitude aligns with result bits 12 down to 6.
// - event set above set-high, released below clear-high; low side symmetric.
// - event output high while event present, low after it passes or status clear.
// - offset magnitudes ship as zero.
`timescale 1ns/10ps
module alert_threshold_offset_config #(
	parameter int PROG_CYCLES = alert_cfg_pkg::PROG_CYCLES
) (
	input  wire logic        core_clk_i,       // clock, 10 MHz
	input  wire logic        rst_i,            // synchronous reset, active high
	input  wire logic        thr_wr_i,         // threshold write strobe
	input  wire logic [1:0]  thr_sel_i,        // which threshold word
	input  wire logic [15:0] thr_data_i,       // threshold word
	input  wire logic [7:0]  thr_crc_i,        // check byte of threshold word
	input  wire logic [1:0]  thr_rd_sel_i,     // threshold word to read back
	input  wire logic        ofs_wr_i,         // offset write strobe
	input  wire logic [15:0] ofs_data_i,       // offset word
	input  wire logic        nvm_xfer_i,       // transfer thresholds to storage
	input  wire logic        meas_valid_i,     // new measurement pulse
	input  wire logic [15:0] hum_raw_i,        // raw humidity result
	input  wire logic [15:0] tmp_raw_i,        // raw temperature result
	input  wire logic        status_clr_i,     // status clear strobe
	output logic      [15:0] thr_rd_data_o,    // selected threshold word
	output logic      [15:0] ofs_rd_data_o,    // current offset word
	output logic             nack_o,           // pulse: refuse current write
	output logic             busy_o,           // storage load after reset or programming in progress
	output logic      [15:0] hum_out_o,        // corrected humidity result
	output logic      [15:0] tmp_out_o,        // corrected temperature result
	output logic             event_o           // event output
);
	initial begin
		if (PROG_CYCLES < 1) $error("PROG_CYCLES must be at least one");
	end

	typedef enum logic [2:0] {ST_LOAD, ST_LOAD_WAIT, ST_IDLE, ST_PROG_THR, ST_PROG_WAIT} state_t;

	// =====================================================================
	// state
	// =====================================================================
	state_t      state_reg, state_next;
	logic [15:0] thr_reg [4];
	logic [15:0] thr_next [4];
	logic [15:0] ofs_reg, ofs_next;
	logic [2:0]  idx_reg, idx_next;
	logic [31:0] cnt_reg, cnt_next;
	logic        nack_reg, nack_next;
	logic        hi_ev_reg, hi_ev_next;
	logic        lo_ev_reg, lo_ev_next;
	logic        event_reg, event_next;
	logic [15:0] hum_out_reg, hum_out_next;
	logic [15:0] tmp_out_reg, tmp_out_next;
	logic [15:0] thr_rd_reg, thr_rd_next;
	logic        busy_reg, busy_next;

	logic [7:0]  crc_calc;
	logic        nvm_wr;
	logic [2:0]  nvm_waddr;
	logic [15:0] nvm_wdata;
	logic [15:0] nvm_rdata;
	logic        nvm_rvalid;

	threshold_crc8 u_crc (
		.data_i (thr_data_i),
		.crc_o  (crc_calc)
	);

	nvm_store #(.DEPTH(alert_cfg_pkg::NVM_WORDS), .AW(3)) u_nvm (
		.core_clk_i (core_clk_i),
		.wr_i       (nvm_wr),
		.waddr_i    (nvm_waddr),
		.wdata_i    (nvm_wdata),
		.raddr_i    (idx_reg),
		.rdata_o    (nvm_rdata),
		.rvalid_o   (nvm_rvalid)
	);

	// =====================================================================
	// configuration and storage sequencing
	// =====================================================================
	always_comb begin
		state_next = state_reg;
		for (int i = 0; i < 4; i++) thr_next[i] = thr_reg[i];
		ofs_next  = ofs_reg;
		idx_next  = idx_reg;
		cnt_next  = cnt_reg;
		nack_next = 1'b0;
		nvm_wr    = 1'b0;
		nvm_waddr = idx_reg;
		nvm_wdata = thr_reg[idx_reg[1:0]];
		unique case (state_reg)
			ST_LOAD: begin
				state_next = ST_LOAD_WAIT;
			end
			ST_LOAD_WAIT: begin
				if (nvm_rvalid) begin
					// storage read data lag the address by one cycle, hence the wait state
					if (idx_reg == alert_cfg_pkg::NVM_OFFSET_ADDR) begin
						ofs_next = nvm_rdata;
					end else begin
						thr_next[idx_reg[1:0]] = nvm_rdata;
					end
				end
				if (idx_reg == alert_cfg_pkg::NVM_OFFSET_ADDR) begin
					idx_next   = 3'h0;
					state_next = ST_IDLE;
				end else begin
					idx_next   = idx_reg + 3'h1;
					state_next = ST_LOAD;
				end
			end
			ST_IDLE: begin
				if (thr_wr_i) begin
					if (crc_calc == thr_crc_i) begin
						thr_next[thr_sel_i] = thr_data_i;
					end else begin
						nack_next = 1'b1;
					end
				end else if (ofs_wr_i) begin
					ofs_next   = ofs_data_i;
					nvm_wr     = 1'b1;
					nvm_waddr  = alert_cfg_pkg::NVM_OFFSET_ADDR;
					nvm_wdata  = ofs_data_i;
					cnt_next   = 32'(PROG_CYCLES);
					state_next = ST_PROG_WAIT;
				end else if (nvm_xfer_i) begin
					idx_next   = 3'h0;
					state_next = ST_PROG_THR;
				end
			end
			ST_PROG_THR: begin
				nvm_wr = 1'b1;
				if (idx_reg == 3'h3) begin
					idx_next   = 3'h0;
					cnt_next   = 32'(PROG_CYCLES);
					state_next = ST_PROG_WAIT;
				end else begin
					idx_next = idx_reg + 3'h1;
				end
			end
			ST_PROG_WAIT: begin
				if (cnt_reg <= 32'h1) begin
					state_next = ST_IDLE;
				end else begin
					cnt_next = cnt_reg - 32'h1;
				end
			end
		endcase
		// busy follows the next state so the pin comes straight from a flop
		busy_next = (state_next != ST_IDLE);
	end

	// =====================================================================
	// offset application and event tracking
	// =====================================================================
	logic [15:0] hum_mag, tmp_mag;
	logic [16:0] hum_sum, tmp_sum;
	logic [6:0]  hum_tr, sh_h, ch_h, sl_h, cl_h;
	logic [8:0]  tmp_tr, sh_t, ch_t, sl_t, cl_t;
	logic        hum_track, tmp_track;
	logic        hi_set, hi_clr, lo_set, lo_clr;

	always_comb begin
		hum_mag = 16'(ofs_reg[alert_cfg_pkg::HUM_MAG_LSB +: alert_cfg_pkg::OFS_MAG_W]) << alert_cfg_pkg::HUM_OFS_ALIGN;
		tmp_mag = 16'(ofs_reg[alert_cfg_pkg::TMP_MAG_LSB +: alert_cfg_pkg::OFS_MAG_W]) << alert_cfg_pkg::TMP_OFS_ALIGN;
		// humidity and temperature corrected independently; clamp at range ends
		if (ofs_reg[alert_cfg_pkg::HUM_SIGN_BIT]) begin
			hum_sum = {1'b0, hum_raw_i} + {1'b0, hum_mag};
			hum_out_next = hum_sum[16] ? 16'hFFFF : hum_sum[15:0];
		end else begin
			hum_sum = {1'b0, hum_raw_i} - {1'b0, hum_mag};
			hum_out_next = hum_sum[16] ? 16'h0000 : hum_sum[15:0];
		end
		if (ofs_reg[alert_cfg_pkg::TMP_SIGN_BIT]) begin
			tmp_sum = {1'b0, tmp_raw_i} + {1'b0, tmp_mag};
			tmp_out_next = tmp_sum[16] ? 16'hFFFF : tmp_sum[15:0];
		end else begin
			tmp_sum = {1'b0, tmp_raw_i} - {1'b0, tmp_mag};
			tmp_out_next = tmp_sum[16] ? 16'h0000 : tmp_sum[15:0];
		end
		if (!meas_valid_i) begin
			hum_out_next = hum_out_reg;
			tmp_out_next = tmp_out_reg;
		end
		hum_tr = hum_out_next[15 -: alert_cfg_pkg::HUM_FIELD_W];
		tmp_tr = tmp_out_next[15 -: alert_cfg_pkg::TMP_FIELD_W];
		sh_h = thr_reg[alert_cfg_pkg::SEL_SET_HIGH][15 -: alert_cfg_pkg::HUM_FIELD_W];
		ch_h = thr_reg[alert_cfg_pkg::SEL_CLEAR_HIGH][15 -: alert_cfg_pkg::HUM_FIELD_W];
		sl_h = thr_reg[alert_cfg_pkg::SEL_SET_LOW][15 -: alert_cfg_pkg::HUM_FIELD_W];
		cl_h = thr_reg[alert_cfg_pkg::SEL_CLEAR_LOW][15 -: alert_cfg_pkg::HUM_FIELD_W];
		sh_t = thr_reg[alert_cfg_pkg::SEL_SET_HIGH][alert_cfg_pkg::TMP_FIELD_W-1:0];
		ch_t = thr_reg[alert_cfg_pkg::SEL_CLEAR_HIGH][alert_cfg_pkg::TMP_FIELD_W-1:0];
		sl_t = thr_reg[alert_cfg_pkg::SEL_SET_LOW][alert_cfg_pkg::TMP_FIELD_W-1:0];
		cl_t = thr_reg[alert_cfg_pkg::SEL_CLEAR_LOW][alert_cfg_pkg::TMP_FIELD_W-1:0];
		hum_track = !(sl_h > sh_h);
		tmp_track = !(sl_t > sh_t);
		hi_set = (hum_track && hum_tr > sh_h) || (tmp_track && tmp_tr > sh_t);
		hi_clr = (!hum_track || hum_tr < ch_h) && (!tmp_track || tmp_tr < ch_t);
		lo_set = (hum_track && hum_tr < sl_h) || (tmp_track && tmp_tr < sl_t);
		lo_clr = (!hum_track || hum_tr > cl_h) && (!tmp_track || tmp_tr > cl_t);
		hi_ev_next = hi_ev_reg;
		lo_ev_next = lo_ev_reg;
		if (meas_valid_i) begin
			// a measurement in the same cycle as a status clear wins
			if (hi_set) begin
				hi_ev_next = 1'b1;
			end else if (hi_clr) begin
				hi_ev_next = 1'b0;
			end
			if (lo_set) begin
				lo_ev_next = 1'b1;
			end else if (lo_clr) begin
				lo_ev_next = 1'b0;
			end
		end else if (status_clr_i) begin
			hi_ev_next = 1'b0;
			lo_ev_next = 1'b0;
		end
		event_next = hi_ev_next || lo_ev_next;
	end

	// =====================================================================
	// sequencer registers
	// =====================================================================
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_reg   <= ST_LOAD;
			thr_reg[alert_cfg_pkg::SEL_SET_HIGH]   <= alert_cfg_pkg::SET_HIGH_RST;
			thr_reg[alert_cfg_pkg::SEL_CLEAR_HIGH] <= alert_cfg_pkg::CLEAR_HIGH_RST;
			thr_reg[alert_cfg_pkg::SEL_SET_LOW]    <= alert_cfg_pkg::SET_LOW_RST;
			thr_reg[alert_cfg_pkg::SEL_CLEAR_LOW]  <= alert_cfg_pkg::CLEAR_LOW_RST;
			ofs_reg     <= alert_cfg_pkg::OFFSET_RST;
			idx_reg     <= 3'h0;
			cnt_reg     <= 32'h0;
			nack_reg    <= 1'b0;
			busy_reg    <= 1'b1;
		end else begin
			state_reg   <= state_next;
			for (int i = 0; i < 4; i++) thr_reg[i] <= thr_next[i];
			ofs_reg     <= ofs_next;
			idx_reg     <= idx_next;
			cnt_reg     <= cnt_next;
			nack_reg    <= nack_next;
			busy_reg    <= busy_next;
		end
	end

	// =====================================================================
	// measurement registers
	// =====================================================================
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			hi_ev_reg   <= 1'b0;
			lo_ev_reg   <= 1'b0;
			event_reg   <= 1'b0;
			hum_out_reg <= 16'h0000;
			tmp_out_reg <= 16'h0000;
		end else begin
			hi_ev_reg   <= hi_ev_next;
			lo_ev_reg   <= lo_ev_next;
			event_reg   <= event_next;
			hum_out_reg <= hum_out_next;
			tmp_out_reg <= tmp_out_next;
		end
	end

	// =====================================================================
	// threshold read-back
	// =====================================================================
	always_comb begin
		thr_rd_next = thr_reg[thr_rd_sel_i];
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			thr_rd_reg <= 16'h0000;
		end else begin
			thr_rd_reg <= thr_rd_next;
		end
	end

	assign thr_rd_data_o = thr_rd_reg;
	assign ofs_rd_data_o = ofs_reg;
	assign nack_o        = nack_reg;
	assign busy_o        = busy_reg;
	assign hum_out_o     = hum_out_reg;
	assign tmp_out_o     = tmp_out_reg;
	assign event_o       = event_reg;
endmodule : alert_threshold_offset_config

// >>> test/alert_cfg_asserts.sv
// Purpose: port checks for the threshold and offset block
// Assumes: PROG_CYCLES at least 8; no measurement in the cycle an offset write lands
// Notes:   bound to every instance of the block
`timescale 1ns/10ps
module alert_cfg_asserts #(
	parameter int PROG_CYCLES = 8
) (
	input wire logic        core_clk_i,    // clock
	input wire logic        rst_i,         // reset
	input wire logic        thr_wr_i,      // thr write
	input wire logic        ofs_wr_i,      // ofs write
	input wire logic [15:0] ofs_data_i,    // ofs word
	input wire logic        meas_valid_i,  // new result
	input wire logic [15:0] hum_raw_i,     // raw hum
	input wire logic [15:0] tmp_raw_i,     // raw tmp
	input wire logic        status_clr_i,  // clear
	input wire logic [15:0] ofs_rd_data_o, // ofs now
	input wire logic        nack_o,        // refusal
	input wire logic        busy_o,        // busy
	input wire logic [15:0] hum_out_o,     // hum out
	input wire logic [15:0] tmp_out_o,     // tmp out
	input wire logic        event_o        // event
);
	initial begin
		if (PROG_CYCLES < 8) $error("checker needs PROG_CYCLES of at least 8");
	end
	// ====================
	// expected corrected results
	logic        ofs_take;
	logic [16:0] h_sum;
	logic [16:0] t_sum;
	logic [15:0] h_exp;
	logic [15:0] t_exp;
	assign ofs_take = ofs_wr_i && !thr_wr_i && !busy_o;
	assign h_sum    = ofs_rd_data_o[15] ? {1'b0, hum_raw_i} + {3'h0, ofs_rd_data_o[14:8], 7'h00}
		: {1'b0, hum_raw_i} - {3'h0, ofs_rd_data_o[14:8], 7'h00};
	assign t_sum    = ofs_rd_data_o[7] ? {1'b0, tmp_raw_i} + {4'h0, ofs_rd_data_o[6:0], 6'h00}
		: {1'b0, tmp_raw_i} - {4'h0, ofs_rd_data_o[6:0], 6'h00};
	// out of range ends at the rail the sign points to
	assign h_exp    = h_sum[16] ? {16{ofs_rd_data_o[15]}} : h_sum[15:0];
	assign t_exp    = t_sum[16] ? {16{ofs_rd_data_o[7]}} : t_sum[15:0];
	// ====================
	// properties
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	property p_nack_pulse; nack_o |=> !nack_o; endproperty
	a_nack_pulse: assert property (p_nack_pulse) else $error("nack wider than one cycle");
	property p_nack_cause; nack_o |-> $past(thr_wr_i) && !$past(busy_o); endproperty
	a_nack_cause: assert property (p_nack_cause) else $error("nack without a write");
	property p_ofs_store; ofs_take |=> ofs_rd_data_o == $past(ofs_data_i); endproperty
	a_ofs_store: assert property (p_ofs_store) else $error("offset word not taken");
	property p_ofs_busy; ofs_take |=> busy_o [*8]; endproperty
	a_ofs_busy: assert property (p_ofs_busy) else $error("offset programming too short");
	property p_hum_corr; meas_valid_i |=> hum_out_o == $past(h_exp); endproperty
	a_hum_corr: assert property (p_hum_corr) else $error("humidity correction wrong");
	property p_tmp_corr; meas_valid_i |=> tmp_out_o == $past(t_exp); endproperty
	a_tmp_corr: assert property (p_tmp_corr) else $error("temperature correction wrong");
	property p_evt_clear; status_clr_i && !meas_valid_i |=> !event_o; endproperty
	a_evt_clear: assert property (p_evt_clear) else $error("event kept after clear");
	property p_rst_busy; $fell(rst_i) |-> busy_o [*8]; endproperty
	a_rst_busy: assert property (p_rst_busy) else $error("no load phase after reset");
	c_nack: cover property (nack_o);
	c_event: cover property ($rose(event_o));
	c_ofs: cover property (ofs_take);
endmodule : alert_cfg_asserts

bind alert_threshold_offset_config alert_cfg_asserts #(.PROG_CYCLES(PROG_CYCLES)) i_alert_cfg_asserts (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .thr_wr_i(thr_wr_i), .ofs_wr_i(ofs_wr_i), .ofs_data_i(ofs_data_i),
	.meas_valid_i(meas_valid_i), .hum_raw_i(hum_raw_i), .tmp_raw_i(tmp_raw_i), .status_clr_i(status_clr_i),
	.ofs_rd_data_o(ofs_rd_data_o), .nack_o(nack_o), .busy_o(busy_o), .hum_out_o(hum_out_o),
	.tmp_out_o(tmp_out_o), .event_o(event_o));

// >>> test/host_model.sv
// Purpose: host side issuing threshold, offset and transfer requests
// Assumes: block samples requests on rising edges
// Notes:   requests change on the falling edge; released data is inverted
`timescale 1ns/10ps
module host_model (
	input  wire logic        core_clk_i, // clock
	input  wire logic        busy_i,     // block busy
	input  wire logic        nack_i,     // refusal
	output logic             thr_wr_o,   // thr write
	output logic      [1:0]  thr_sel_o,  // thr select
	output logic      [15:0] thr_data_o, // thr word
	output logic      [7:0]  thr_crc_o,  // check byte
	output logic             ofs_wr_o,   // ofs write
	output logic      [15:0] ofs_data_o, // ofs word
	output logic             xfer_o      // store thresholds
);
	initial begin
		{thr_wr_o, ofs_wr_o, xfer_o} = 3'h0;
		{thr_sel_o, thr_data_o, thr_crc_o, ofs_data_o} = 42'h0;
	end
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
		end
		return c;
	endfunction : crc8
	// no automatic measurement is modelled, so every request comes from sleep
	task automatic wait_idle();
		// always let an edge pass so no strobe is lowered and raised in one time step
		@(negedge core_clk_i);
		while (busy_i !== 1'b0) begin
			@(negedge core_clk_i);
		end
	endtask : wait_idle
	task automatic put_thr(input logic [1:0] sel, input logic [15:0] w, input logic bad, output logic nk);
		wait_idle();
		thr_sel_o  = sel;
		thr_data_o = w;
		thr_crc_o  = crc8(w) ^ {7'h00, bad};
		thr_wr_o   = 1'b1;
		@(negedge core_clk_i);
		thr_wr_o   = 1'b0;
		thr_data_o = ~w;
		nk         = nack_i;
	endtask : put_thr
	task automatic put_ofs(input logic [15:0] w);
		wait_idle();
		ofs_data_o = w;
		ofs_wr_o   = 1'b1;
		@(negedge core_clk_i);
		ofs_wr_o   = 1'b0;
		ofs_data_o = ~w;
	endtask : put_ofs
	task automatic xfer();
		wait_idle();
		xfer_o = 1'b1;
		@(negedge core_clk_i);
		xfer_o = 1'b0;
	endtask : xfer
endmodule : host_model

// >>> test/testbench.sv
// Purpose: self-checking bench for the threshold and offset block
// Assumes: PROG_CYCLES of 8
// Notes:   inputs change on the falling edge
`timescale 1ns/10ps
module testbench;
	logic        core_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        thr_wr_i, ofs_wr_i, nvm_xfer_i, nack_o, busy_o, event_o, nk;
	logic        meas_valid_i = 1'b0;
	logic        status_clr_i = 1'b0;
	logic [1:0]  thr_sel_i;
	logic [1:0]  thr_rd_sel_i = 2'h0;
	logic [7:0]  thr_crc_i;
	logic [15:0] thr_data_i, ofs_data_i, thr_rd_data_o, ofs_rd_data_o, hum_out_o, tmp_out_o;
	logic [15:0] hum_raw_i = 16'h0000;
	logic [15:0] tmp_raw_i = 16'h0000;
	int          bad_count = 0;
	int          n_compared = 0;
	int          cycles = 0;
	always #50 core_clk_i = ~core_clk_i;
	alert_threshold_offset_config #(.PROG_CYCLES(8)) i_alert_threshold_offset_config (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .thr_wr_i(thr_wr_i), .thr_sel_i(thr_sel_i),
		.thr_data_i(thr_data_i), .thr_crc_i(thr_crc_i), .thr_rd_sel_i(thr_rd_sel_i), .ofs_wr_i(ofs_wr_i),
		.ofs_data_i(ofs_data_i), .nvm_xfer_i(nvm_xfer_i), .meas_valid_i(meas_valid_i), .hum_raw_i(hum_raw_i),
		.tmp_raw_i(tmp_raw_i), .status_clr_i(status_clr_i), .thr_rd_data_o(thr_rd_data_o),
		.ofs_rd_data_o(ofs_rd_data_o), .nack_o(nack_o), .busy_o(busy_o), .hum_out_o(hum_out_o),
		.tmp_out_o(tmp_out_o), .event_o(event_o));
	host_model i_host_model (
		.core_clk_i(core_clk_i), .busy_i(busy_o), .nack_i(nack_o), .thr_wr_o(thr_wr_i), .thr_sel_o(thr_sel_i),
		.thr_data_o(thr_data_i), .thr_crc_o(thr_crc_i), .ofs_wr_o(ofs_wr_i), .ofs_data_o(ofs_data_i),
		.xfer_o(nvm_xfer_i));
	// ====================
	// helpers
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rd(input logic [1:0] sel, input logic [15:0] exp);
		thr_rd_sel_i = sel;
		@(negedge core_clk_i);
		chk("threshold", exp, thr_rd_data_o);
	endtask : rd
	task automatic meas(input logic [15:0] h, t, eh, et, input logic ev);
		{meas_valid_i, hum_raw_i, tmp_raw_i} = {1'b1, h, t};
		@(negedge core_clk_i);
		{meas_valid_i, hum_raw_i, tmp_raw_i} = {1'b0, ~h, ~t};
		chk("hum_out", eh, hum_out_o);
		chk("tmp_out", et, tmp_out_o);
		chk("event", {15'h0, ev}, {15'h0, event_o});
	endtask : meas
	task automatic reset_dut();
		rst_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		rst_i = 1'b0;
		i_host_model.wait_idle();
	endtask : reset_dut
	// ====================
	// scenarios
	task automatic t_defaults();
		logic [15:0] dflt [4] = '{16'hCD33, 16'hCB2D, 16'h3266, 16'h3869};
		for (int i = 0; i < 4; i++) begin
			rd(i[1:0], dflt[i]);
		end
		chk("offset", 16'h0000, ofs_rd_data_o);
	endtask : t_defaults
	task automatic t_crc();
		i_host_model.put_thr(alert_cfg_pkg::SEL_SET_HIGH, 16'hE741, 1'b0, nk);
		chk("nack", 16'h0000, {15'h0, nk});
		rd(2'h0, 16'hE741);
		i_host_model.put_thr(alert_cfg_pkg::SEL_CLEAR_LOW, 16'h1234, 1'b1, nk);
		chk("nack", 16'h0001, {15'h0, nk});
		rd(2'h3, 16'h3869);
	endtask : t_crc
	task automatic t_event();
		meas(16'hE800, 16'h8000, 16'hE800, 16'h8000, 1'b1);
		meas(16'h8000, 16'h8000, 16'h8000, 16'h8000, 1'b0);
		meas(16'h2000, 16'h8000, 16'h2000, 16'h8000, 1'b1);
		status_clr_i = 1'b1;
		@(negedge core_clk_i);
		status_clr_i = 1'b0;
		chk("event", 16'h0000, {15'h0, event_o});
		meas(16'hE7FF, 16'h8000, 16'hE7FF, 16'h8000, 1'b0);
		i_host_model.put_thr(alert_cfg_pkg::SEL_SET_LOW, 16'hFE66, 1'b0, nk);
		meas(16'hE800, 16'h8000, 16'hE800, 16'h8000, 1'b0);
		i_host_model.put_thr(alert_cfg_pkg::SEL_SET_LOW, 16'h33FF, 1'b0, nk);
		meas(16'h8000, 16'hFF00, 16'h8000, 16'hFF00, 1'b0);
		i_host_model.put_thr(alert_cfg_pkg::SEL_SET_LOW, 16'h3266, 1'b0, nk);
	endtask : t_event
	task automatic t_offset();
		i_host_model.put_ofs(16'h8A2A);
		chk("offset", 16'h8A2A, ofs_rd_data_o);
		chk("busy", 16'h0001, {15'h0, busy_o});
		i_host_model.wait_idle();
		meas(16'h4000, 16'h6000, 16'h4500, 16'h5580, 1'b0);
		meas(16'hFFF0, 16'h0100, 16'hFFFF, 16'h0000, 1'b1);
	endtask : t_offset
	task automatic t_nvm();
		i_host_model.xfer();
		chk("busy", 16'h0001, {15'h0, busy_o});
		i_host_model.wait_idle();
		reset_dut();
		rd(2'h0, 16'hE741);
		rd(2'h1, 16'hCB2D);
		rd(2'h2, 16'h3266);
		rd(2'h3, 16'h3869);
		chk("offset", 16'h8A2A, ofs_rd_data_o);
	endtask : t_nvm
	initial begin
		reset_dut();
		t_defaults();
		t_crc();
		t_event();
		t_offset();
		t_nvm();
		end_sim();
	end
endmodule : testbench
